/* File: src/dcbc_top.v */
// dma command decoder, transfer control and byte counter
`timescale 1ns/1ps
`include "dcbc_defines.vh"
module dcbc_top #(
  parameter FIFO_DEPTH = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire usb_bus_reset,
  input wire dma_in_valid,
  input wire [7:0] dma_in_data,
  input wire dma_out_strobe,
  input wire out_burst_end,
  input wire out_fifo_empty,
  input wire ep_wr_ready,
  output reg ep_wr_valid,
  output reg [7:0] ep_wr_data,
  output reg ep_tx_clear,
  output reg ep_ptr_restart,
  output reg ep_out_release,
  output reg dreq,
  output reg dack,
  output reg diow,
  output reg dior,
  output reg tf_rd_req,
  output reg [9:0] tf_addr,
  input wire tf_rd_ack,
  input wire [7:0] tf_rd_data
);
  // transfer states
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_DRAIN = 2'h2;

  reg [1:0] state; // transfer state
  reg run_generic; // running transfer is generic slave mode
  reg dir_in; // running transfer moves dma bus to endpoint
  reg stop_pend; // generic stop waiting for burst end
  reg stop_by_cmd; // drain was caused by a generic stop command
  reg in_burst; // an out burst is under way
  reg [31:0] count; // bytes outstanding
  reg cnt_dis; // counter disable setting
  reg [7:0] last_cmd; // last command written
  reg stop_done; // sticky: generic stop finished
  reg task_done; // sticky: task-file read finished
  reg [1:0] core_rst_cnt; // core reset sequence length
  reg addr_wr; // data phase of a write pending
  reg [7:0] addr_q; // latched write address
  wire core_rst; // core reset in progress
  wire fifo_flush;
  wire fifo_in_ready;
  wire [3:0] fifo_level;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire tf_busy;
  wire tf_req_w;
  wire [9:0] tf_addr_w;
  wire [7:0] tf_data;
  wire tf_done;
  wire addr_phase;
  wire wr_cmd;
  wire wr_count;
  wire wr_cfg;
  wire wr_stat;
  wire [7:0] cmd;
  wire byte_moved;
  wire cnt_active;
  wire last_byte;
  wire in_take;
  wire tf_start;

  // --------------------------------------------------------------------------
  // ahb-lite slave: zero wait state, always okay
  // --------------------------------------------------------------------------
  assign addr_phase = hsel & hready & htrans[1];
  assign wr_cmd = addr_wr & (addr_q == `DCBC_OFF_CMD);
  assign wr_count = addr_wr & (addr_q == `DCBC_OFF_COUNT);
  assign wr_cfg = addr_wr & (addr_q == `DCBC_OFF_CFG);
  assign wr_stat = addr_wr & (addr_q == `DCBC_OFF_STAT);
  assign cmd = hwdata[7:0];

  // latch the write address; read data is set up for the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_wr <= 1'b0;
      addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      addr_wr <= addr_phase & hwrite;
      addr_q <= haddr[7:0];
      if (addr_phase && !hwrite) begin
        // unmapped words read as zero
        case (haddr[7:0])
          `DCBC_OFF_CMD: hrdata <= {24'h0, last_cmd};
          `DCBC_OFF_COUNT: hrdata <= count;
          `DCBC_OFF_CFG: hrdata <= {24'h0, cnt_dis, 7'h0};
          `DCBC_OFF_STAT: hrdata <= {16'h0, tf_data, 1'b0, fifo_level[3:0] == 4'h0,
                                     core_rst, state != ST_IDLE, tf_busy, 1'b0,
                                     task_done, stop_done};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // byte accounting
  // --------------------------------------------------------------------------
  assign in_take = (state == ST_RUN) & dir_in & dma_in_valid & dreq & fifo_in_ready;
  assign byte_moved = in_take | ((state == ST_RUN) & ~dir_in & dma_out_strobe);
  assign cnt_active = ~(cnt_dis & run_generic);
  assign last_byte = byte_moved & cnt_active & (count == 32'h0000_0001);
  assign core_rst = (core_rst_cnt != 2'h0);
  assign fifo_flush = core_rst;
  assign tf_start = wr_cmd & ~core_rst & (cmd >= `DCBC_CMD_TF_FIRST) &
                    (cmd <= `DCBC_CMD_TF_LAST);

  // counter: software write wins over a byte in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= `DCBC_COUNT_RESET;
    end else if (usb_bus_reset || core_rst) begin
      count <= `DCBC_COUNT_RESET;
    end else if (wr_count) begin
      count <= hwdata;
    end else if (byte_moved) begin
      // wraps through zero in a generic run with the counter disabled rather than stopping
      count <= count - 32'h0000_0001;
    end
  end

  // configuration: counter disable bit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_dis <= `DCBC_CFG_RESET;
    end else if (usb_bus_reset || core_rst) begin
      cnt_dis <= `DCBC_CFG_RESET;
    end else if (wr_cfg) begin
      cnt_dis <= hwdata[`DCBC_CFG_CNT_DIS];
    end
  end

  // --------------------------------------------------------------------------
  // core reset sequence
  // --------------------------------------------------------------------------
  // the handshake lines pulse while the core is reset; an external
  // controller must only be started after this has ended
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_rst_cnt <= 2'h0;
    end else if (wr_cmd && cmd == `DCBC_CMD_CORE_RST && !core_rst) begin
      core_rst_cnt <= `DCBC_CORE_RST_CYC;
    end else if (core_rst) begin
      core_rst_cnt <= core_rst_cnt - 2'h1;
    end
  end

  // --------------------------------------------------------------------------
  // command execution and transfer state
  // --------------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      run_generic <= 1'b0;
      dir_in <= 1'b0;
      stop_pend <= 1'b0;
      stop_by_cmd <= 1'b0;
      in_burst <= 1'b0;
      last_cmd <= 8'h00;
      ep_tx_clear <= 1'b0;
      ep_ptr_restart <= 1'b0;
      ep_out_release <= 1'b0;
    end else if (core_rst) begin
      // everything except last_cmd back to its power-on value
      state <= ST_IDLE;
      run_generic <= 1'b0;
      dir_in <= 1'b0;
      stop_pend <= 1'b0;
      stop_by_cmd <= 1'b0;
      in_burst <= 1'b0;
      ep_tx_clear <= 1'b0;
      ep_ptr_restart <= 1'b0;
      ep_out_release <= 1'b0;
    end else begin
      ep_tx_clear <= 1'b0;
      ep_ptr_restart <= 1'b0;
      ep_out_release <= 1'b0;
      // track out bursts so a generic stop lands between them
      if (dma_out_strobe && state == ST_RUN && !dir_in) begin
        in_burst <= 1'b1;
      end
      if (out_burst_end) begin
        in_burst <= 1'b0;
      end
      if (wr_cmd) begin
        last_cmd <= cmd;
        case (cmd)
          `DCBC_CMD_GEN_IN, `DCBC_CMD_GEN_OUT,
          `DCBC_CMD_MW_IN, `DCBC_CMD_MW_OUT: begin
            if (state == ST_IDLE) begin
              state <= ST_RUN;
              run_generic <= (cmd == `DCBC_CMD_GEN_IN) | (cmd == `DCBC_CMD_GEN_OUT);
              dir_in <= (cmd == `DCBC_CMD_GEN_IN) | (cmd == `DCBC_CMD_MW_IN);
              stop_by_cmd <= 1'b0;
              in_burst <= 1'b0;
            end
          end
          // only the transmit side of the indexed endpoint is cleared;
          // a double buffer needs this command issued twice
          `DCBC_CMD_CLR_BUF: ep_tx_clear <= 1'b1;
          `DCBC_CMD_RESTART: ep_ptr_restart <= 1'b1;
          `DCBC_CMD_MW_STOP: begin
            if (state == ST_RUN && !run_generic) begin
              state <= ST_DRAIN;
            end
          end
          `DCBC_CMD_GEN_STOP: begin
            if (state == ST_RUN && run_generic) begin
              stop_pend <= 1'b1;
            end
          end
          // reserved codes fall through with no effect
          default: ;
        endcase
      end
      // generic stop: in takes effect at once, out waits for burst end
      if (state == ST_RUN && stop_pend &&
          (dir_in || !in_burst || out_burst_end)) begin
        state <= ST_DRAIN;
        stop_pend <= 1'b0;
        stop_by_cmd <= 1'b1;
      end else if (state == ST_RUN && last_byte) begin
        state <= ST_DRAIN;
      end
      // in: wait for the fifo to reach the endpoint; out: unsent data
      // stays in the endpoint and release waits for the fifo to empty
      if (state == ST_DRAIN) begin
        if (dir_in && fifo_level == 4'h0 && !ep_wr_valid) begin
          state <= ST_IDLE;
        end else if (!dir_in && out_fifo_empty) begin
          state <= ST_IDLE;
          ep_out_release <= 1'b1;
        end
      end
      // a stop that met the last byte must not stop the next run
      if (state != ST_RUN) begin
        stop_pend <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // sticky status: hardware set wins over a write-one clear
  // --------------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_done <= 1'b0;
      task_done <= 1'b0;
    end else if (core_rst) begin
      stop_done <= 1'b0;
      task_done <= 1'b0;
    end else begin
      if (state == ST_DRAIN && stop_by_cmd &&
          (dir_in ? fifo_level == 4'h0 && !ep_wr_valid : out_fifo_empty)) begin
        stop_done <= 1'b1;
      end else if (wr_stat && hwdata[`DCBC_ST_STOP_DONE]) begin
        stop_done <= 1'b0;
      end
      if (tf_done) begin
        task_done <= 1'b1;
      end else if (wr_stat && hwdata[`DCBC_ST_TASK_DONE]) begin
        task_done <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // dma bus handshake
  // --------------------------------------------------------------------------
  // request only while more than two slots are free, so a byte already on its
  // way when the request drops still fits
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dreq <= 1'b0;
      dack <= 1'b0;
      diow <= 1'b0;
      dior <= 1'b0;
      ep_wr_valid <= 1'b0;
      ep_wr_data <= 8'h00;
      tf_rd_req <= 1'b0;
      tf_addr <= 10'h000;
    end else begin
      dreq <= core_rst | ((state == ST_RUN) & ~stop_pend & ~last_byte &
              (~dir_in | (fifo_level < FIFO_DEPTH - 2)));
      dack <= core_rst;
      diow <= core_rst;
      dior <= core_rst;
      // reload only when empty or taken, so no byte is offered twice
      if (!ep_wr_valid || ep_wr_ready) begin
        ep_wr_valid <= fifo_out_valid;
        ep_wr_data <= fifo_out_data;
      end
      tf_rd_req <= tf_req_w & ~tf_rd_ack; // drops with the answer
      tf_addr <= tf_addr_w;
    end
  end

  // --------------------------------------------------------------------------
  // sub-blocks
  // --------------------------------------------------------------------------
  dcbc_in_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .flush(fifo_flush),
    .in_valid(in_take),
    .in_data(dma_in_data),
    .in_ready(fifo_in_ready),
    .level(fifo_level),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(~ep_wr_valid | ep_wr_ready)
  );

  dcbc_task_reader u_task (
    .hclk(hclk),
    .hresetn(hresetn),
    .flush(core_rst),
    .start(tf_start),
    .index(cmd[2:0] - 3'h1),
    .busy(tf_busy),
    .tf_rd_req(tf_req_w),
    .tf_addr(tf_addr_w),
    .tf_rd_ack(tf_rd_ack),
    .tf_rd_data(tf_rd_data),
    .data(tf_data),
    .done(tf_done)
  );
endmodule

/* File: include/dcbc_defines.vh */
// constants for the dma command and byte counter block
`ifndef DCBC_DEFINES_VH
`define DCBC_DEFINES_VH

// --------------------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------------------
`define DCBC_OFF_CMD 8'h30
`define DCBC_OFF_COUNT 8'h34
`define DCBC_OFF_CFG 8'h38
`define DCBC_OFF_STAT 8'h3c

// --------------------------------------------------------------------------
// field positions and reset values
// --------------------------------------------------------------------------
`define DCBC_CFG_CNT_DIS 7
`define DCBC_ST_STOP_DONE 0
`define DCBC_ST_TASK_DONE 1
`define DCBC_COUNT_RESET 32'h0000_0000
`define DCBC_CFG_RESET 1'b0

// --------------------------------------------------------------------------
// command codes
// --------------------------------------------------------------------------
`define DCBC_CMD_GEN_IN 8'h00
`define DCBC_CMD_GEN_OUT 8'h01
`define DCBC_CMD_MW_IN 8'h06
`define DCBC_CMD_MW_OUT 8'h07
`define DCBC_CMD_CLR_BUF 8'h0f
`define DCBC_CMD_RESTART 8'h10
`define DCBC_CMD_CORE_RST 8'h11
`define DCBC_CMD_MW_STOP 8'h12
`define DCBC_CMD_GEN_STOP 8'h13
`define DCBC_CMD_TF_FIRST 8'h21
`define DCBC_CMD_TF_LAST 8'h28

// --------------------------------------------------------------------------
// timing
// --------------------------------------------------------------------------
`define DCBC_CLK_NS 10
`define DCBC_IN_DRAIN_NS 60
`define DCBC_IN_DRAIN_CYC (`DCBC_IN_DRAIN_NS / `DCBC_CLK_NS)
`define DCBC_CORE_RST_CYC 2'h2

`endif

/* File: src/dcbc_in_fifo.v */
// small in-direction byte fifo that drains into the endpoint buffer
`timescale 1ns/1ps
module dcbc_in_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire flush,
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  output wire [3:0] level,
  output reg out_valid,
  output reg [WIDTH-1:0] out_data,
  input wire out_ready
);
  // storage behind the output stage; the output stage is one more slot
  reg [WIDTH-1:0] mem [0:DEPTH-2];
  reg [2:0] wr_ptr;
  reg [2:0] rd_ptr;
  reg [3:0] cnt;
  wire push;
  wire pop;

  // --------------------------------------------------------------------------
  // flow control
  // --------------------------------------------------------------------------
  assign level = cnt + {3'h0, out_valid};
  assign in_ready = (level < DEPTH);
  assign push = in_valid & in_ready;
  assign pop = (cnt != 4'h0) & (~out_valid | out_ready);

  // --------------------------------------------------------------------------
  // pointers, storage and output stage
  // --------------------------------------------------------------------------
  // a byte moves to the output stage the cycle after entry, so the
  // endpoint sees it well inside the drain limit when it is ready
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      cnt <= 4'h0;
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else if (flush) begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      cnt <= 4'h0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= (wr_ptr == DEPTH - 2) ? 3'h0 : wr_ptr + 3'h1;
      end
      if (pop) begin
        out_data <= mem[rd_ptr];
        rd_ptr <= (rd_ptr == DEPTH - 2) ? 3'h0 : rd_ptr + 3'h1;
      end
      // output stage empties when taken and nothing follows
      if (pop) begin
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      cnt <= cnt + {3'h0, push} - {3'h0, pop};
    end
  end
endmodule

/* File: src/dcbc_task_reader.v */
// sequencer for single task-file register reads
`timescale 1ns/1ps
module dcbc_task_reader (
  input wire hclk,
  input wire hresetn,
  input wire flush,
  input wire start,
  input wire [2:0] index,
  output reg busy,
  output reg tf_rd_req,
  output reg [9:0] tf_addr,
  input wire tf_rd_ack,
  input wire [7:0] tf_rd_data,
  output reg [7:0] data,
  output reg done
);
  // map an index 0..7 onto the task-file address set
  function [9:0] dcbc_tf_addr;
    input [2:0] idx;
    begin
      case (idx)
        3'h6: dcbc_tf_addr = 10'h3f6;
        3'h7: dcbc_tf_addr = 10'h3f7;
        default: dcbc_tf_addr = 10'h1f1 + {7'h0, idx};
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // request and capture
  // --------------------------------------------------------------------------
  // the request holds until the device acknowledges with its data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      tf_rd_req <= 1'b0;
      tf_addr <= 10'h000;
      data <= 8'h00;
      done <= 1'b0;
    end else if (flush) begin
      busy <= 1'b0;
      tf_rd_req <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        tf_rd_req <= 1'b1;
        tf_addr <= dcbc_tf_addr(index);
      end else if (busy && tf_rd_ack) begin
        busy <= 1'b0;
        tf_rd_req <= 1'b0;
        data <= tf_rd_data;
        done <= 1'b1;
      end
    end
  end
endmodule

/* File: testbench/dcbc_properties.sv */
// concurrent checks on the ports of the dma command block
`timescale 1ns/1ps
`include "dcbc_defines.vh"
module dcbc_properties (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hwdata,
  input wire hreadyout,
  input wire hresp,
  input wire ep_tx_clear,
  input wire ep_ptr_restart,
  input wire dreq,
  input wire dack,
  input wire diow,
  input wire dior,
  input wire tf_rd_req,
  input wire [9:0] tf_addr,
  input wire tf_rd_ack,
  input wire dma_in_valid,
  input wire ep_wr_ready,
  input wire ep_wr_valid
);
  // ------
  // helper: data phase of a command write
  // ------
  reg cmd_ph; // address phase to the command register seen last edge
  wire [7:0] code = hwdata[7:0];
  wire cmd_go = cmd_ph && hready;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_ph <= 1'b0;
    end else begin
      cmd_ph <= hsel && hready && htrans[1] && hwrite && (haddr[7:0] == `DCBC_OFF_CMD);
    end
  end
  // task-file address expected for codes 21h..28h
  function [9:0] tf_map(input [7:0] c);
    tf_map = (c < 8'h27) ? 10'h1d0 + {2'b00, c} : 10'h3cf + {2'b00, c};
  endfunction
  // ------
  // properties
  // ------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_pulse(s);
    s ##1 !s;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_clear_pulse: assert property (cmd_go && code == `DCBC_CMD_CLR_BUF |=> s_pulse(ep_tx_clear))
    else $error("clear command gave no single pulse");
  a_restart_pulse: assert property (cmd_go && code == `DCBC_CMD_RESTART |=> s_pulse(ep_ptr_restart))
    else $error("restart command gave no single pulse");
  a_reserved_quiet: assert property (cmd_go && (code inside {[8'h14:8'h20], [8'h29:8'hff]})
    |=> (!ep_tx_clear && !ep_ptr_restart && !tf_rd_req) [*2])
    else $error("reserved code caused activity");
  a_core_handshake: assert property (cmd_go && code == `DCBC_CMD_CORE_RST
    |-> ##[1:3] (dreq && dack && diow && dior))
    else $error("core reset handshake pulse missing");
  a_task_addr: assert property (cmd_go && code >= 8'h21 && code <= 8'h28 && !tf_rd_req
    |-> ##[1:4] (tf_rd_req && tf_addr == tf_map(code)))
    else $error("task-file read address wrong or late");
  a_task_hold: assert property (tf_rd_req && !tf_rd_ack |=> tf_rd_req && $stable(tf_addr))
    else $error("task-file request dropped before answer");
  a_in_drain: assert property (dma_in_valid && dreq && ep_wr_ready |-> ##[0:6] ep_wr_valid)
    else $error("in byte not offered to endpoint in time");
  a_ep_hold: assert property (ep_wr_valid && !ep_wr_ready |=> ep_wr_valid)
    else $error("endpoint byte withdrawn while stalled");
endmodule

/* File: testbench/dcbc_far_side.sv */
// far-side model: dma byte source, endpoint sink and task-file device
`timescale 1ns/1ps
module dcbc_far_side (
  input wire hclk,
  input wire hresetn,
  input wire slow,
  input wire stall,
  input wire load,
  input wire [7:0] budget,
  input wire dreq,
  input wire tf_rd_req,
  input wire [9:0] tf_addr,
  output wire dma_in_valid,
  output reg [7:0] dma_in_data,
  output reg ep_wr_ready,
  output reg tf_rd_ack,
  output reg [7:0] tf_rd_data
);
  reg [7:0] left; // bytes still to offer
  reg [2:0] lag; // cycles the current task-file request has waited
  assign dma_in_valid = (left != 8'h00);
  // source offers bytes only once loaded, until the loaded budget is used up
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left <= 8'h00;
      dma_in_data <= 8'h00;
    end else if (load) begin
      left <= budget;
    end else if (dma_in_valid && dreq) begin
      left <= left - 8'h01;
      dma_in_data <= dma_in_data + 8'h01;
    end else if (!dma_in_valid) begin
      dma_in_data <= ~dma_in_data; // not driven: keep it moving
    end
  end
  // endpoint sink, toggles ready while stalling
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ep_wr_ready <= 1'b1;
    end else begin
      ep_wr_ready <= !stall || !ep_wr_ready;
    end
  end
  // task-file device: answers at once or after four cycles
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lag <= 3'h0;
      tf_rd_ack <= 1'b0;
      tf_rd_data <= 8'h00;
    end else if (tf_rd_req && !tf_rd_ack && lag >= {slow, 2'b00}) begin
      lag <= 3'h0;
      tf_rd_ack <= 1'b1;
      tf_rd_data <= tf_addr[7:0] ^ 8'ha5;
    end else begin
      lag <= tf_rd_req ? lag + 3'h1 : 3'h0;
      tf_rd_ack <= 1'b0;
      tf_rd_data <= ~tf_rd_data; // outside the answer the byte is stale
    end
  end
endmodule

/* File: testbench/dma_command_and_byte_counter_bench.sv */
// self-checking bench for the dma command and byte counter
`timescale 1ns/1ps
`include "dcbc_defines.vh"
bind dcbc_top dcbc_properties i_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hwdata, .hreadyout, .hresp, .ep_tx_clear, .ep_ptr_restart, .dreq, .dack,
  .diow, .dior, .tf_rd_req, .tf_addr, .tf_rd_ack, .dma_in_valid, .ep_wr_ready, .ep_wr_valid);
module dma_command_and_byte_counter_bench;
  // ------
  // signals
  // ------
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg usb_bus_reset = 1'b0;
  reg slow = 1'b0;
  reg load = 1'b0;
  reg [7:0] budget = 8'h00;
  reg [31:0] rdata;
  reg [9:0] ta;
  wire hready, dma_in_valid, ep_wr_ready, ep_wr_valid, tf_rd_req, tf_rd_ack, dreq;
  wire [7:0] dma_in_data, ep_wr_data, tf_rd_data;
  wire [9:0] tf_addr;
  wire [31:0] hrdata;
  integer mismatches = 0, samples_checked = 0, cycles = 0, ep_cnt = 0, base, i;
  initial forever #5 hclk = ~hclk;
  dcbc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(), .usb_bus_reset(usb_bus_reset),
    .dma_in_valid(dma_in_valid), .dma_in_data(dma_in_data), .dma_out_strobe(1'b0),
    .out_burst_end(1'b0), .out_fifo_empty(1'b1), .ep_wr_ready(ep_wr_ready),
    .ep_wr_valid(ep_wr_valid), .ep_wr_data(ep_wr_data), .ep_tx_clear(), .ep_ptr_restart(),
    .ep_out_release(), .dreq(dreq), .dack(), .diow(), .dior(), .tf_rd_req(tf_rd_req),
    .tf_addr(tf_addr), .tf_rd_ack(tf_rd_ack), .tf_rd_data(tf_rd_data));
  dcbc_far_side i_far (.hclk(hclk), .hresetn(hresetn), .slow(slow), .stall(1'b1),
    .load(load), .budget(budget), .dreq(dreq), .tf_rd_req(tf_rd_req), .tf_addr(tf_addr),
    .dma_in_valid(dma_in_valid), .dma_in_data(dma_in_data), .ep_wr_ready(ep_wr_ready),
    .tf_rd_ack(tf_rd_ack), .tf_rd_data(tf_rd_data));
  // count endpoint handshakes mid-cycle
  always @(negedge hclk) if (ep_wr_valid && ep_wr_ready) ep_cnt = ep_cnt + 1;
  // hang guard: the whole run needs a few hundred cycles
  always @(posedge hclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      results;
    end
  end
  // ------
  // tasks
  // ------
  task chk(input [8*8-1:0] what, input [31:0] exp, input [31:0] seen);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // address phase held until hready is sampled high
  task addr_ph(input [7:0] a, input w);
    begin
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      addr_ph(a, 1'b1);
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
    end
  endtask
  task rd(input [7:0] a);
    begin
      addr_ph(a, 1'b0);
      do @(posedge hclk); while (hready !== 1'b1);
      rdata = hrdata;
    end
  endtask
  // poll status until a bit shows, bounded
  task poll(input [31:0] mask);
    integer n;
    begin
      n = 0;
      rd(`DCBC_OFF_STAT);
      while ((rdata & mask) == 32'h0 && n < 100) begin
        rd(`DCBC_OFF_STAT);
        n = n + 1;
      end
      chk("done", mask, rdata & mask);
    end
  endtask
  // load the byte source, then wait for the endpoint to see n bytes
  task feed(input [7:0] n);
    integer k;
    begin
      base = ep_cnt;
      budget <= n;
      load <= 1'b1;
      @(posedge hclk);
      load <= 1'b0;
      for (k = 0; k < 300 && ep_cnt < base + n; k = k + 1) @(posedge hclk);
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // ------
  // tests
  // ------
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`DCBC_OFF_COUNT); chk("count", 32'h0, rdata);
    wr(`DCBC_OFF_COUNT, 32'h0403_0201);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40); chk("unmap", 32'h0, rdata);
    rd(`DCBC_OFF_COUNT); chk("count", 32'h0403_0201, rdata);
    $display("test registers done");
    wr(`DCBC_OFF_CMD, 32'h0f);
    wr(`DCBC_OFF_CMD, 32'h0f);
    wr(`DCBC_OFF_CMD, 32'h10);
    for (i = 0; i < 4; i = i + 1) wr(`DCBC_OFF_CMD, {24'h0, i[1] ? (i[0] ? 8'hff : 8'h29)
      : (i[0] ? 8'h20 : 8'h14)});
    rd(`DCBC_OFF_COUNT); chk("count", 32'h0403_0201, rdata);
    $display("test commands done");
    for (i = 0; i < 8; i = i + 1) begin
      slow <= i[0];
      ta = (i < 6) ? 10'h1f1 + i[9:0] : 10'h3f0 + i[9:0];
      wr(`DCBC_OFF_CMD, 32'h21 + i);
      poll(32'h2);
      chk("tfbyte", {24'h0, ta[7:0] ^ 8'ha5}, {24'h0, rdata[15:8]});
      wr(`DCBC_OFF_STAT, 32'h2);
    end
    $display("test task reads done");
    wr(`DCBC_OFF_COUNT, 32'h5);
    wr(`DCBC_OFF_CMD, 32'h00);
    feed(8'h5);
    chk("inbytes", 32'h5, ep_cnt - base);
    rd(`DCBC_OFF_COUNT); chk("count", 32'h0, rdata);
    rd(`DCBC_OFF_STAT); chk("busy", 32'h0, rdata & 32'h10);
    wr(`DCBC_OFF_CFG, 32'h80);
    wr(`DCBC_OFF_COUNT, 32'h2);
    wr(`DCBC_OFF_CMD, 32'h00);
    feed(8'h4);
    wr(`DCBC_OFF_CMD, 32'h13);
    poll(32'h1);
    chk("inbytes", 32'h4, ep_cnt - base);
    rd(`DCBC_OFF_COUNT); chk("count", 32'hffff_fffe, rdata);
    wr(`DCBC_OFF_STAT, 32'h1);
    $display("test generic in done");
    wr(`DCBC_OFF_COUNT, 32'h2);
    wr(`DCBC_OFF_CMD, 32'h06);
    feed(8'h3);
    repeat (10) @(posedge hclk);
    chk("inbytes", 32'h2, ep_cnt - base);
    feed(8'h0);
    wr(`DCBC_OFF_COUNT, 32'd50);
    wr(`DCBC_OFF_CMD, 32'h06);
    feed(8'h3);
    wr(`DCBC_OFF_CMD, 32'h12);
    rd(`DCBC_OFF_COUNT); chk("count", 32'd47, rdata);
    rd(`DCBC_OFF_STAT); chk("busy", 32'h0, rdata & 32'h10);
    $display("test multiword done");
    wr(`DCBC_OFF_COUNT, 32'h7);
    wr(`DCBC_OFF_CMD, 32'h11);
    repeat (4) @(posedge hclk);
    rd(`DCBC_OFF_COUNT); chk("count", 32'h0, rdata);
    rd(`DCBC_OFF_CFG); chk("config", 32'h0, rdata & 32'h80);
    wr(`DCBC_OFF_COUNT, 32'h9);
    usb_bus_reset <= 1'b1;
    @(posedge hclk);
    usb_bus_reset <= 1'b0;
    rd(`DCBC_OFF_COUNT); chk("count", 32'h0, rdata);
    $display("test resets done");
    results;
  end
endmodule
